// ---- dv/weight_serial_protocol_bench.sv ----
`timescale 1ns/1ps
module weight_serial_protocol_bench import wsp_pkg::*; ;
  logic clk, sys_rst, rxValid, rxError, txReady, txValid;
  wsp_mode_type mode;
  wsp_weight_type weight;
  wsp_mbreq_type mbReq;
  wsp_mbans_type mbAnswer;
  logic [7:0] rxData, txData;
  logic keyPin, in2Pin, mbDone, grossSel, netSel, zeroCmd, storeCmd, mbOverrun;
  logic [9:0] replyDelaySetting;
  logic [95:0] sp;
  logic [7:0] spSum;
  integer nPulse = 0;
  integer miscompares = 0;
  integer n_tests = 0;
  integer seed = 32'h3170;
  logic [7:0] expq[$];
  logic [1:0] mbq[$];
  logic [31:0] letters = "SMOE";
  wsp_serial_engine #(.CYC_PER_MS(10), .CONT_CYCLES(200)) uut (
    .clk(clk), .sys_rst(sys_rst), .mode(mode), .stationAddr(7'h01),
    .replyDelaySetting(replyDelaySetting), .weight(weight), .keyPin(keyPin), .in2Pin(in2Pin),
    .rxData(rxData), .rxValid(rxValid), .rxError(rxError), .mbReq(mbReq),
    .mbDone(mbDone), .txReady(txReady), .txData(txData), .txValid(txValid),
    .setpointOneField(), .setpointTwoField(), .grossSel(grossSel), .netSel(netSel),
    .zeroCmd(zeroCmd), .storeCmd(storeCmd), .mbAnswer(mbAnswer), .mbOverrun(mbOverrun)
  );
  always @(posedge clk) nPulse += grossSel + netSel + zeroCmd + storeCmd;
  wsp_master_model m (
    .clk(clk), .rxData(rxData), .rxValid(rxValid), .rxError(rxError),
    .txReady(txReady)
  );
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Any byte or answer without a pending note is a mismatch
  always @(posedge clk) begin
    if (txValid === 1'b1 && txReady === 1'b1) begin
      n_tests++;
      if (expq.size() == 0 || expq[0] !== txData) begin
        miscompares++;
        $display("mismatch %0t tx byte %h", $time, txData);
      end
      if (expq.size() != 0) void'(expq.pop_front());
    end
    if (mbAnswer.valid === 1'b1) begin
      n_tests++;
      if (mbq.size() == 0 || mbq[0] !== mbAnswer.code) begin
        miscompares++;
        $display("mismatch %0t answer code %h", $time, mbAnswer.code);
      end
      if (mbq.size() != 0) void'(mbq.pop_front());
    end
  end
  function automatic logic [7:0] hexc(input logic [3:0] h);
    return (h < 4'hA) ? 8'h30 + h : 8'h37 + h;
  endfunction
  task automatic rep(input logic [7:0] q[$]);
    foreach (q[i]) expq.push_back(q[i]);
  endtask
  task automatic cmd(input logic [7:0] q[$]);
    foreach (q[i]) m.send(q[i]);
    m.send(8'h04);
  endtask
  // Weight reply (bc=0) or broadcast frame (bc=1), checksum worked out here
  task automatic frame(input logic bc);
    logic [7:0] cs;
    logic [7:0] b;
    logic [143:0] f;
    f = {weight.net, weight.gross, weight.peak};
    b = letters[31 - 8 * weight.status -: 8];
    cs = bc ? b : 8'h81 ^ b;
    if (bc) rep('{8'h02, b});
    else rep('{8'h4E, 8'h81, b});
    for (int i = 17; i >= 0; i--) begin
      expq.push_back(f[8 * i +: 8]);
      cs ^= f[8 * i +: 8];
    end
    rep('{8'h03, hexc(cs[7:4]), hexc(cs[3:0]), 8'h04});
  endtask
  task automatic drain;
    for (int i = 0; i < 600 && expq.size() + mbq.size() != 0; i++) @(negedge clk);
    if (expq.size() + mbq.size() != 0) begin
      miscompares++;
      $display("mismatch %0t reply missing", $time);
    end
    repeat (10) @(negedge clk);
  endtask
  task automatic end_of_test;
    if (miscompares == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    end_of_test;
  end
  initial begin
    mode = WSP_MODE_SLAVE;
    mbReq = '0;
    {weight.net, weight.gross} = {$random(seed), $random(seed), $random(seed)};
    weight.peak = {$random(seed), 16'h3031};
    weight.status = wsp_wstat_type'(2'($random(seed)));
    weight.div = 24'h00_0000;
    {keyPin, in2Pin, mbDone} = 3'h0;
    replyDelaySetting = 10'h000;
    sys_rst = 1'b1;
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    rep('{8'h81, 8'h43, 8'h4C, 8'h06, 8'h04});
    cmd('{8'h81, 8'h43, 8'h4C});
    drain;
    rep('{8'h81, 8'h43, 8'h4E, 8'h06, 8'h04});
    cmd('{8'h81, 8'h43, 8'h4E});
    drain;
    rep('{8'h81, 8'h41, 8'h41, 8'h06, 8'h04});
    cmd('{8'h81, 8'h41, 8'h41});
    drain;
    frame(1'b0);
    cmd('{8'h81, 8'h4E});
    drain;
    replyDelaySetting = 10'h003;
    rep('{8'h81, 8'h4D, 8'h06, 8'h04});
    cmd('{8'h81, 8'h4D});
    repeat (25) @(negedge clk);
    if (expq.size() != 4) begin
      miscompares++;
      $display("mismatch %0t reply not delayed", $time);
    end
    drain;
    replyDelaySetting = 10'h000;
    rep('{8'h81, 8'h15, 8'h04});
    cmd('{8'h81, 8'h5A});
    drain;
    rep('{8'h81, 8'h15, 8'h04});
    m.send(8'h81);
    m.send(8'h4D, 1'b1);
    m.send(8'h04);
    drain;
    sp = {$random(seed), $random(seed), $random(seed)} | 96'h3030_3030_3030_3030_3030_3030;
    spSum = 8'h81 ^ 8'h53;
    for (int i = 11; i >= 0; i--) spSum ^= sp[8 * i +: 8];
    rep('{8'h81, 8'h53, 8'h06, 8'h04});
    m.send(8'h81);
    m.send(8'h53);
    for (int i = 11; i >= 0; i--) m.send(sp[8 * i +: 8]);
    cmd('{8'h03, hexc(spSum[7:4]), hexc(spSum[3:0])});
    drain;
    spSum ^= 8'h01;
    rep('{8'h81, 8'h52});
    for (int i = 11; i >= 0; i--) expq.push_back(sp[8 * i +: 8]);
    rep('{8'h03, hexc(spSum[7:4]), hexc(spSum[3:0]), 8'h04});
    cmd('{8'h81, 8'h52});
    drain;
    cmd('{8'h82, 8'h43, 8'h4C});
    drain;
    mode = WSP_MODE_MODBUS;
    for (int k = 0; k < 6; k++) begin
      // k=0 carries a bad CRC and must stay silent; k=5 overruns its limit
      mbReq = '{1'b1, k != 0, k != 1, k != 2, k != 3, 2'h0};
      if (k != 0) mbq.push_back((k > 3) ? 2'h0 : 2'(k));
      @(negedge clk);
      mbReq.valid = 1'b0;
      repeat ((k == 5) ? 230 : 0) @(negedge clk);
      if (k == 5 && mbOverrun !== 1'b1) begin
        miscompares++;
        $display("mismatch %0t no overrun", $time);
      end
      mbDone = k > 3;
      @(negedge clk);
      mbDone = 1'b0;
      repeat (12) @(negedge clk);
    end
    drain;
    mode = WSP_MODE_NONE;
    frame(1'b1);
    mode = WSP_MODE_CONTIN;
    drain;
    weight.status = WSP_ST_STABLE;
    weight.div = 24'h00_0020;
    mode = WSP_MODE_DEMAND;
    frame(1'b1);
    keyPin = 1'b1;
    repeat (6) @(negedge clk);
    keyPin = 1'b0;
    drain;
    // Same weight again: a press on input 2 must send nothing
    in2Pin = 1'b1;
    repeat (6) @(negedge clk);
    in2Pin = 1'b0;
    drain;
    weight.div = 24'h00_0040;
    frame(1'b1);
    mode = WSP_MODE_AUTOM;
    drain;
    mode = WSP_MODE_NONE;
    if (nPulse !== 4) begin
      miscompares++;
      $display("mismatch %0t command pulses %0d", $time, nPulse);
    end
    end_of_test;
  end
endmodule // weight_serial_protocol_bench

// ---- dv/wsp_master_model.sv ----
`timescale 1ns/1ps
module wsp_master_model (
  input wire logic clk,
  output logic [7:0] rxData,
  output logic rxValid,
  output logic rxError,
  output logic txReady
);
  integer seed = 32'h3170;
  initial begin
    rxData = 8'h00;
    rxValid = 1'b0;
    rxError = 1'b0;
    txReady = 1'b1;
  end
  // Random stalls so the two-entry buffer is exercised
  always @(negedge clk) begin
    txReady <= ($random(seed) & 3) != 0;
  end
  // Master alone opens an exchange, one byte per pulse
  task automatic send(input logic [7:0] b, input logic e = 1'b0);
    @(negedge clk);
    rxData = b;
    rxValid = 1'b1;
    rxError = e;
    @(negedge clk);
    rxValid = 1'b0;
    rxError = 1'b0;
    // Idle line shows no stale byte
    rxData = ~b;
  endtask
endmodule // wsp_master_model

// ---- verilog/wsp_consts.svh ----
`ifndef WSP_CONSTS_SVH
`define WSP_CONSTS_SVH

// Framing bytes
`define WSP_STX 8'h02
`define WSP_ETX 8'h03
`define WSP_EOT 8'h04
`define WSP_ACK 8'h06
`define WSP_NAK 8'h15
`define WSP_ADDR_BASE 8'h80

// ASCII letters and digits
`define WSP_CH_N 8'h4E
`define WSP_CH_C 8'h43
`define WSP_CH_L 8'h4C
`define WSP_CH_A 8'h41
`define WSP_CH_S 8'h53
`define WSP_CH_R 8'h52
`define WSP_CH_M 8'h4D
`define WSP_CH_O 8'h4F
`define WSP_CH_E 8'h45
`define WSP_CH_ZERO 8'h30
`define WSP_CH_NINE 8'h39
`define WSP_CH_F 8'h46
`define WSP_HEX_ALPHA 8'h37

// Frame lengths in bytes, before any checksum digits and the end-of-transmission byte
`define WSP_LEN_BCAST 5'h15
`define WSP_LEN_WEIGHT 5'h16
`define WSP_LEN_SETP 5'h0F
`define WSP_LEN_ACK2 5'h04
`define WSP_LEN_ACK1 5'h03
`define WSP_LEN_NAK 5'h02
`define WSP_XOR_SKIP1 5'h01
`define WSP_TAIL_EOT 2'h2

// Received setpoint command layout, bytes after the address
`define WSP_S_LEN 5'h10
`define WSP_S_XOR_BYTES 5'h0D
`define WSP_RX_OVER 5'h11

// Station address and reply delay
`define WSP_ADDR_MAX 7'h63
`define WSP_ADDR_DEFAULT 7'h01
`define WSP_DELAY_MAX_MS 10'h3E7
`define WSP_WAIT_SAT 10'h3FF

// Weight change and minimum weight, in divisions
`define WSP_MIN_CHANGE 25'sh000_0014
`define WSP_MIN_WEIGHT 24'sh00_0014

// Timing
`define WSP_CLK_MHZ 32'h0000_0064
`define WSP_CONT_RATE_HZ 32'h0000_000A
`define WSP_MB_LIMIT_MS 10'h014
`define WSP_MB_BACKUP_MS 10'h15E
`define WSP_MB_CAL_MS 10'h226

`endif

// ---- verilog/wsp_pair_buffer.sv ----
`timescale 1ns/1ps
module wsp_pair_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic [CW-1:0] wrPos;
  logic push;
  logic pop;

  assign inReady = count != CW'(DEPTH);
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign next_count = count + CW'(push) - CW'(pop);
  // New word lands behind whatever survives this cycle's shift
  assign wrPos = count - CW'(pop);
  assign outData = mem[0];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count <= '0;
      outValid <= 1'b0;
    end else begin
      count <= next_count;
      outValid <= next_count != '0;
    end
  end

  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        mem[i] <= '0;
      end else if (push && wrPos == CW'(i)) begin
        mem[i] <= inData;
      end else if (pop) begin
        if (i < DEPTH - 1) begin
          mem[i] <= mem[(i + 1) % DEPTH];
        end else begin
          mem[i] <= '0;
        end
      end
    end
  end

endmodule // wsp_pair_buffer

// ---- verilog/wsp_pkg.sv ----
package wsp_pkg;

  typedef enum logic [2:0] {
    WSP_MODE_NONE = 3'b000,
    WSP_MODE_CONTIN = 3'b001,
    WSP_MODE_DEMAND = 3'b010,
    WSP_MODE_AUTOM = 3'b011,
    WSP_MODE_SLAVE = 3'b100,
    WSP_MODE_MODBUS = 3'b101,
    WSP_MODE_PRINT = 3'b110
  } wsp_mode_type;

  typedef enum logic [1:0] {
    WSP_ST_STABLE = 2'b00,
    WSP_ST_MOVING = 2'b01,
    WSP_ST_OVER = 2'b10,
    WSP_ST_ERROR = 2'b11
  } wsp_wstat_type;

  typedef struct packed {
    wsp_wstat_type status;
    logic [47:0] net;
    logic [47:0] gross;
    logic [47:0] peak;
    logic signed [23:0] div;
  } wsp_weight_type;

  // Timing class: 0 plain, 1 backup, 2 calibration write
  typedef struct packed {
    logic valid;
    logic crcOk;
    logic funcOk;
    logic addrOk;
    logic valueOk;
    logic [1:0] timing;
  } wsp_mbreq_type;

  typedef struct packed {
    logic valid;
    logic [1:0] code;
  } wsp_mbans_type;

  typedef enum logic [1:0] {
    WSP_TX_IDLE = 2'b00,
    WSP_TX_WAIT = 2'b01,
    WSP_TX_BODY = 2'b10,
    WSP_TX_TAIL = 2'b11
  } wsp_tx_type;

  typedef enum logic [1:0] {
    WSP_RX_IDLE = 2'b00,
    WSP_RX_OWN = 2'b01,
    WSP_RX_SKIP = 2'b10
  } wsp_rx_type;

endpackage

// ---- verilog/wsp_serial_engine.sv ----
`timescale 1ns/1ps
`include "wsp_consts.svh"
// Overview of operation
// [RQ1] Broadcast framed by STX, ETX, then EOT
// [RQ2] Status letter S, M, O or E
// [RQ3] Net, gross, peak each six characters
// [RQ4] Broadcast checksum XOR, two hex characters
// [RQ5] Continuous mode sends at ten hertz
// [RQ6] Auto/demand need twenty divisions change
// [RQ7] Master starts; one reply per command
// [RQ8] Weight request gets full weight reply
// [RQ9] CL and CN answered with ACK
// [RQ10] AA triggers zero action, ACK reply
// [RQ11] S loads both setpoints, ACK reply
// [RQ12] R returns both setpoints with checksum
// [RQ13] M stores setpoints, ACK reply
// [RQ14] Error or unknown command gets NAK
// [RQ15] Address character is address plus 80h
// [RQ16] Slave checksum from address, nibbles hex
// [RQ17] Setpoint fields are six characters
// [RQ18] Poll rate bounded by line speed
// [RQ19] Reply delayed 0 to 999 ms
// [RQ20] Modbus answer time limits 20/350/550 ms
// [RQ21] Modbus CRC failure gets no reply
// [RQ22] Modbus exception codes one, two, three
// [RQ23] Station address 0 to 99, default 1
// [RQ24] Demand honoured only with stable weight
// [RQ25] Foreign address commands silently ignored
module wsp_serial_engine
  import wsp_pkg::*;
#(
  parameter int CYC_PER_MS = `WSP_CLK_MHZ * 1000,
  parameter int CONT_CYCLES = (`WSP_CLK_MHZ * 1000000) / `WSP_CONT_RATE_HZ
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire wsp_mode_type mode,
  input wire logic [6:0] stationAddr,
  input wire logic [9:0] replyDelaySetting,
  input wire wsp_weight_type weight,
  input wire logic keyPin,
  input wire logic in2Pin,
  input wire logic [7:0] rxData,
  input wire logic rxValid,
  input wire logic rxError,
  input wire wsp_mbreq_type mbReq,
  input wire logic mbDone,
  input wire logic txReady,
  output logic [7:0] txData,
  output logic txValid,
  output logic [47:0] setpointOneField,
  output logic [47:0] setpointTwoField,
  output logic grossSel,
  output logic netSel,
  output logic zeroCmd,
  output logic storeCmd,
  output wsp_mbans_type mbAnswer,
  output logic mbOverrun
);

  function automatic logic [7:0] hexChar(input logic [3:0] n);
    hexChar = (n < 4'hA) ? (`WSP_CH_ZERO + {4'h0, n}) : (`WSP_HEX_ALPHA + {4'h0, n});
  endfunction

  // Configuration
  logic [6:0] addrEff;
  logic [7:0] ownChar;
  logic [9:0] delayEff;
  logic [7:0] statChar;
  assign addrEff = (stationAddr > `WSP_ADDR_MAX) ? `WSP_ADDR_DEFAULT : stationAddr; // RQ23
  assign ownChar = `WSP_ADDR_BASE + {1'b0, addrEff}; // RQ15
  assign delayEff = (replyDelaySetting > `WSP_DELAY_MAX_MS) ? `WSP_DELAY_MAX_MS
                                                            : replyDelaySetting;
  assign statChar = (weight.status == WSP_ST_STABLE) ? `WSP_CH_S :
                    (weight.status == WSP_ST_MOVING) ? `WSP_CH_M :
                    (weight.status == WSP_ST_OVER) ? `WSP_CH_O : `WSP_CH_E; // RQ2

  // Key and input 2: three stages, level taken when stages two and three agree
  logic [1:0] reqS1;
  logic [1:0] reqS2;
  logic [1:0] reqS3;
  logic [1:0] reqLvl;
  logic [1:0] reqPrv;
  logic [1:0] reqAgree;
  logic [1:0] next_reqLvl;
  logic reqEdge;
  assign reqAgree = ~(reqS2 ^ reqS3);
  assign next_reqLvl = (reqS2 & reqAgree) | (reqLvl & ~reqAgree);
  assign reqEdge = |(reqLvl & ~reqPrv);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reqS1 <= 2'h0;
      reqS2 <= 2'h0;
      reqS3 <= 2'h0;
      reqLvl <= 2'h0;
      reqPrv <= 2'h0;
    end else begin
      reqS1 <= {in2Pin, keyPin};
      reqS2 <= reqS1;
      reqS3 <= reqS2;
      reqLvl <= next_reqLvl;
      reqPrv <= reqLvl;
    end
  end

  // Command receiver
  wsp_rx_type rxState;
  logic [4:0] rxCount;
  logic [127:0] rxHist;
  logic [7:0] rxXor;
  logic rxBad;
  logic rxOn;
  logic rxEot;
  assign rxOn = mode == WSP_MODE_SLAVE;
  assign rxEot = rxOn && rxValid && rxState == WSP_RX_OWN && rxData == `WSP_EOT;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rxState <= WSP_RX_IDLE;
      rxCount <= 5'h00;
      rxHist <= '0;
      rxXor <= 8'h00;
      rxBad <= 1'b0;
    end else if (!rxOn) begin
      rxState <= WSP_RX_IDLE;
    end else if (rxValid) begin
      unique case (rxState)
        WSP_RX_IDLE: begin
          // Only an address character opens an exchange
          if (rxData[7]) begin // RQ7
            rxState <= (rxData == ownChar) ? WSP_RX_OWN : WSP_RX_SKIP; // RQ25
            rxCount <= 5'h00;
            rxXor <= rxData; // RQ16
            rxBad <= rxError;
          end
        end
        WSP_RX_SKIP: begin
          if (rxData == `WSP_EOT) begin
            rxState <= WSP_RX_IDLE;
          end
        end
        WSP_RX_OWN: begin
          if (rxData == `WSP_EOT) begin
            rxState <= WSP_RX_IDLE;
          end else begin
            rxHist <= {rxHist[119:0], rxData};
            if (rxCount != `WSP_RX_OVER) begin
              rxCount <= rxCount + 5'h01;
            end
            if (rxCount < `WSP_S_XOR_BYTES) begin
              rxXor <= rxXor ^ rxData; // RQ16
            end
            if (rxError) begin
              rxBad <= 1'b1;
            end
          end
        end
        default: begin
          rxState <= WSP_RX_IDLE;
        end
      endcase
    end
  end

  // Command decode at end-of-transmission
  logic [7:0] c0;
  logic [7:0] c1;
  logic one;
  logic two;
  logic cmdN;
  logic cmdR;
  logic cmdM;
  logic cmdCL;
  logic cmdCN;
  logic cmdAA;
  logic cmdS;
  logic sumOk;
  assign c0 = rxHist[15:8];
  assign c1 = rxHist[7:0];
  assign one = !rxBad && rxCount == 5'h01;
  assign two = !rxBad && rxCount == 5'h02;
  assign cmdN = one && c1 == `WSP_CH_N; // RQ8
  assign cmdR = one && c1 == `WSP_CH_R; // RQ12
  assign cmdM = one && c1 == `WSP_CH_M; // RQ13
  assign cmdCL = two && c0 == `WSP_CH_C && c1 == `WSP_CH_L; // RQ9
  assign cmdCN = two && c0 == `WSP_CH_C && c1 == `WSP_CH_N; // RQ9
  assign cmdAA = two && c0 == `WSP_CH_A && c1 == `WSP_CH_A; // RQ10
  assign sumOk = rxHist[15:0] == {hexChar(rxXor[7:4]), hexChar(rxXor[3:0])}; // RQ16
  assign cmdS = !rxBad && rxCount == `WSP_S_LEN && rxHist[127:120] == `WSP_CH_S
                && rxHist[23:16] == `WSP_ETX && sumOk; // RQ11

  // Reply frames, left aligned in a 24-byte shifter
  logic [191:0] frameWeight;
  logic [191:0] frameSetp;
  logic [191:0] frameAck2;
  logic [191:0] frameAck1;
  logic [191:0] frameNak;
  logic [191:0] frameBcast;
  logic [191:0] replyFrame;
  logic [4:0] replyLen;
  logic replyTwo;
  logic replyOne;
  assign frameWeight = {`WSP_CH_N, ownChar, statChar, weight.net, weight.gross, weight.peak,
                        `WSP_ETX, {2{8'h00}}}; // RQ8
  assign frameSetp = {ownChar, `WSP_CH_R, setpointOneField, setpointTwoField, `WSP_ETX,
                      {9{8'h00}}}; // RQ12 RQ17
  assign frameAck2 = {ownChar, c0, c1, `WSP_ACK, {20{8'h00}}}; // RQ9 RQ10
  assign frameAck1 = {ownChar, (cmdS ? `WSP_CH_S : `WSP_CH_M), `WSP_ACK, {21{8'h00}}}; // RQ13
  assign frameNak = {ownChar, `WSP_NAK, {22{8'h00}}}; // RQ14
  assign frameBcast = {`WSP_STX, statChar, weight.net, weight.gross, weight.peak, `WSP_ETX,
                       {3{8'h00}}}; // RQ1 RQ3
  assign replyTwo = cmdCL || cmdCN || cmdAA;
  assign replyOne = cmdM || cmdS;
  assign replyFrame = cmdN ? frameWeight : cmdR ? frameSetp : replyTwo ? frameAck2 :
                      replyOne ? frameAck1 : frameNak;
  assign replyLen = cmdN ? `WSP_LEN_WEIGHT : cmdR ? `WSP_LEN_SETP : replyTwo ? `WSP_LEN_ACK2 :
                    replyOne ? `WSP_LEN_ACK1 : `WSP_LEN_NAK;

  // Broadcast triggers
  logic [31:0] contCnt;
  logic contTick;
  logic signed [23:0] lastDiv;
  logic sentOnce;
  logic signed [24:0] wDiff;
  logic farMove;
  logic stable;
  logic autoGo;
  logic demandGo;
  logic bcastGo;
  assign contTick = contCnt == 32'(CONT_CYCLES - 1);
  assign wDiff = {weight.div[23], weight.div} - {lastDiv[23], lastDiv};
  assign farMove = !sentOnce || wDiff >= `WSP_MIN_CHANGE || wDiff <= -`WSP_MIN_CHANGE; // RQ6
  assign stable = weight.status == WSP_ST_STABLE;
  assign autoGo = mode == WSP_MODE_AUTOM && stable && farMove
                  && weight.div >= `WSP_MIN_WEIGHT; // RQ6
  assign demandGo = mode == WSP_MODE_DEMAND && reqEdge && stable && farMove; // RQ24
  // Filter setting has no say in the rate
  assign bcastGo = (mode == WSP_MODE_CONTIN && contTick) || autoGo || demandGo; // RQ5

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      contCnt <= 32'h0000_0000;
    end else begin
      contCnt <= contTick ? 32'h0000_0000 : contCnt + 32'h0000_0001;
    end
  end

  // Sender
  wsp_tx_type txState;
  logic [191:0] frame;
  logic [4:0] txLen;
  logic [4:0] txFrom;
  logic txSum;
  logic [4:0] txIdx;
  logic [7:0] txXor;
  logic [1:0] tailIdx;
  logic txIdle;
  logic slaveStart;
  logic bcastStart;
  logic pushValid;
  logic [7:0] pushByte;
  logic bufReady;
  logic push;
  logic xorHit;
  logic delayDone;
  assign txIdle = txState == WSP_TX_IDLE;
  // A command arriving while a reply is still going out is dropped
  assign slaveStart = rxEot && txIdle; // RQ7
  assign bcastStart = bcastGo && txIdle;
  assign pushValid = txState == WSP_TX_BODY || txState == WSP_TX_TAIL;
  assign pushByte = (txState == WSP_TX_BODY) ? frame[191:184] :
                    (tailIdx == 2'h0) ? hexChar(txXor[7:4]) :
                    (tailIdx == 2'h1) ? hexChar(txXor[3:0]) : `WSP_EOT; // RQ4 RQ16
  // Stall by the line stalls the sender, so poll rate follows baud
  assign push = pushValid && bufReady; // RQ18
  assign xorHit = txIdx >= txFrom && txIdx < txLen - 5'h01; // RQ4 RQ16

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      txState <= WSP_TX_IDLE;
      frame <= '0;
      txLen <= 5'h00;
      txFrom <= 5'h00;
      txSum <= 1'b0;
      txIdx <= 5'h00;
      txXor <= 8'h00;
      tailIdx <= 2'h0;
    end else begin
      unique case (txState)
        WSP_TX_IDLE: begin
          if (slaveStart || bcastStart) begin
            frame <= slaveStart ? replyFrame : frameBcast;
            txLen <= slaveStart ? replyLen : `WSP_LEN_BCAST;
            txFrom <= (slaveStart && !cmdN) ? 5'h00 : `WSP_XOR_SKIP1;
            txSum <= slaveStart ? (cmdN || cmdR) : 1'b1;
            txIdx <= 5'h00;
            txXor <= 8'h00;
            txState <= slaveStart ? WSP_TX_WAIT : WSP_TX_BODY;
          end
        end
        WSP_TX_WAIT: begin
          if (delayDone) begin
            txState <= WSP_TX_BODY; // RQ19
          end
        end
        WSP_TX_BODY: begin
          if (push) begin
            frame <= {frame[183:0], 8'h00};
            txIdx <= txIdx + 5'h01;
            if (xorHit) begin
              txXor <= txXor ^ pushByte;
            end
            if (txIdx == txLen - 5'h01) begin
              txState <= WSP_TX_TAIL;
              tailIdx <= txSum ? 2'h0 : `WSP_TAIL_EOT;
            end
          end
        end
        WSP_TX_TAIL: begin
          if (push) begin
            if (tailIdx == `WSP_TAIL_EOT) begin
              txState <= WSP_TX_IDLE; // RQ1
            end else begin
              tailIdx <= tailIdx + 2'h1;
            end
          end
        end
      endcase
    end
  end

  // Last weight broadcast, for the change threshold
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lastDiv <= 24'sh00_0000;
      sentOnce <= 1'b0;
    end else if (bcastStart) begin
      lastDiv <= weight.div; // RQ6
      sentOnce <= 1'b1;
    end
  end

  // Command side effects
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      grossSel <= 1'b0;
      netSel <= 1'b0;
      zeroCmd <= 1'b0;
      storeCmd <= 1'b0;
      setpointOneField <= '0;
      setpointTwoField <= '0;
    end else begin
      grossSel <= slaveStart && cmdCL; // RQ9
      netSel <= slaveStart && cmdCN; // RQ9
      zeroCmd <= slaveStart && cmdAA; // RQ10
      storeCmd <= slaveStart && cmdM; // RQ13
      if (slaveStart && cmdS) begin
        setpointOneField <= rxHist[119:72]; // RQ11 RQ17
        setpointTwoField <= rxHist[71:24]; // RQ11 RQ17
      end
    end
  end

  // Millisecond delay timer, restarted by each slave reply start and each accepted Modbus request
  logic [31:0] msPre;
  logic [9:0] waitMs;
  logic msTick;
  logic schedStart;
  logic mbOn;
  logic mbStart;
  logic mbPend;
  logic mbExec;
  logic mbFire;
  logic [1:0] mbCode;
  logic [1:0] next_mbCode;
  logic [9:0] mbLimit;
  assign msTick = msPre == 32'(CYC_PER_MS - 1);
  assign delayDone = waitMs >= delayEff; // RQ19
  assign schedStart = slaveStart || mbStart;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      msPre <= 32'h0000_0000;
      waitMs <= 10'h000;
    end else if (schedStart || msTick) begin
      msPre <= 32'h0000_0000;
      waitMs <= schedStart ? 10'h000 : (waitMs == `WSP_WAIT_SAT) ? waitMs : waitMs + 10'h001;
    end else begin
      msPre <= msPre + 32'h0000_0001;
    end
  end

  // Modbus answer timing and exception selection
  assign mbOn = mode == WSP_MODE_MODBUS;
  assign mbStart = mbOn && mbReq.valid && mbReq.crcOk && !mbPend; // RQ21
  assign next_mbCode = !mbReq.funcOk ? 2'h1 : !mbReq.addrOk ? 2'h2 :
                       !mbReq.valueOk ? 2'h3 : 2'h0; // RQ22
  // Exceptions need no execution, so they only wait out the delay
  assign mbFire = mbPend && delayDone && (mbExec || mbDone);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mbPend <= 1'b0;
      mbExec <= 1'b0;
      mbCode <= 2'h0;
      mbLimit <= `WSP_MB_LIMIT_MS;
      mbAnswer <= '0;
      mbOverrun <= 1'b0;
    end else begin
      mbAnswer <= {mbFire, mbCode}; // RQ22
      if (mbStart) begin
        mbPend <= 1'b1;
        mbCode <= next_mbCode;
        mbExec <= next_mbCode != 2'h0;
        mbOverrun <= 1'b0;
        mbLimit <= (mbReq.timing == 2'h1) ? `WSP_MB_BACKUP_MS :
                   (mbReq.timing == 2'h2) ? `WSP_MB_CAL_MS : `WSP_MB_LIMIT_MS; // RQ20
      end else begin
        if (mbFire) begin
          mbPend <= 1'b0;
        end
        if (mbDone) begin
          mbExec <= 1'b1;
        end
        if (mbPend && !mbExec && !mbDone && waitMs >= mbLimit) begin
          mbOverrun <= 1'b1; // RQ20
        end
      end
    end
  end

  wsp_pair_buffer #(
    .WIDTH(8),
    .DEPTH(2)
  ) u_txbuf (
    .clk(clk),
    .sys_rst(sys_rst),
    .inData(pushByte),
    .inValid(pushValid),
    .inReady(bufReady),
    .outData(txData),
    .outValid(txValid),
    .outReady(txReady)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence seq_bcast_go;
    bcastStart;
  endsequence
  sequence seq_foreign;
    rxOn && rxValid && rxState == WSP_RX_IDLE && rxData[7] && rxData != ownChar;
  endsequence

  a_stx_lead: assert property (seq_bcast_go |=> txState == WSP_TX_BODY // RQ1
    && pushByte == `WSP_STX) else $error("broadcast does not open with STX");
  a_eot_close: assert property (push && txState == WSP_TX_TAIL // RQ1
    && tailIdx == `WSP_TAIL_EOT |-> pushByte == `WSP_EOT ##1 txIdle)
    else $error("frame not closed by EOT");
  a_status_letter: assert property (seq_bcast_go |=> frame[183:176] inside // RQ2
    {`WSP_CH_S, `WSP_CH_M, `WSP_CH_O, `WSP_CH_E}) else $error("bad status letter");
  a_hex_digits: assert property (push && txState == WSP_TX_TAIL // RQ4
    && tailIdx != `WSP_TAIL_EOT |-> pushByte inside {[`WSP_CH_ZERO:`WSP_CH_NINE],
    [`WSP_CH_A:`WSP_CH_F]}) else $error("checksum digit not hex");
  a_foreign_quiet: assert property (seq_foreign |=> rxState == WSP_RX_SKIP // RQ25
    && !rxEot) else $error("foreign frame not skipped");
  a_zero_delay: assert property (slaveStart && delayEff == 10'h000 // RQ19
    |=> txState == WSP_TX_WAIT ##1 txState == WSP_TX_BODY)
    else $error("zero delay reply held back");
  a_crc_silent: assert property (mbOn && mbReq.valid && !mbReq.crcOk && !mbPend // RQ21
    |=> (!mbPend && !mbAnswer.valid) [*2]) else $error("reply to bad CRC");
  a_exc_func: assert property (mbStart && !mbReq.funcOk |=> mbPend // RQ22
    && mbCode == 2'h1 && mbExec) else $error("wrong exception code");
  a_ack_gross: assert property (slaveStart && cmdCL |=> txState == WSP_TX_WAIT // RQ9
    && frame[191:160] == {$past(ownChar), `WSP_CH_C, `WSP_CH_L, `WSP_ACK} && grossSel)
    else $error("gross switch reply wrong");
  a_nak_reply: assert property (slaveStart && !cmdN && !cmdR && !replyTwo // RQ14
    && !replyOne |=> txLen == `WSP_LEN_NAK && frame[183:176] == `WSP_NAK && !txSum)
    else $error("error reply not NAK");

endmodule // wsp_serial_engine
